// file: halt_cfg_pkg.sv
// Purpose: constants and types shared by the halt configuration bank
// Assumes: 25 MHz core clock
// Notes: field positions refer to loop settings word B only, word C holds no decoded field
package halt_cfg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] SETTINGS_B_ADDR = 8'h88;
  localparam logic [7:0] SETTINGS_C_ADDR = 8'h8A;
  localparam logic [31:0] SETTINGS_B_RST = 32'h0000_0000;
  localparam logic [31:0] SETTINGS_C_RST = 32'h0140_0000;

  // ****************************************
  // field positions in the second word
  // ****************************************
  localparam int PULSE_CFG_BIT = 24;
  localparam int EMF_THR_LSB = 21;
  localparam int HALT_LSB = 18;
  localparam int BRAKE_TIME_LSB = 14;
  localparam int SPIN_THR_LSB = 11;
  localparam int PIN_THR_LSB = 8;
  localparam int LIMIT_LSB = 3;

  // field reset values
  localparam logic [2:0] EMF_THR_RST = 3'h0;
  localparam logic [2:0] HALT_RST = 3'h0;
  localparam logic [3:0] LIMIT_RST = 4'h0;

  // legal code masks, one bit per code
  localparam logic [7:0] EMF_THR_VALID = 8'h3F;
  localparam logic [7:0] HALT_VALID = 8'h1F;
  localparam logic [15:0] LIMIT_VALID = 16'hFFFE;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    HALT_HIZ,
    HALT_RECIRC,
    HALT_LOW_BRAKE,
    HALT_HIGH_BRAKE,
    HALT_SPIN_DOWN
  } halt_method_type;

  typedef enum logic [2:0] {
    DRV_RUN,
    DRV_HIZ,
    DRV_RECIRC,
    DRV_LOW_BRAKE,
    DRV_HIGH_BRAKE,
    DRV_SPIN_DOWN
  } drive_mode_type;

  typedef struct packed {
    logic [14:0] emf_thr_uv;
    logic [10:0] limit_mv;
    logic [9:0] spin_thr_pm;
    logic [9:0] pin_thr_pm;
    logic [13:0] brake_ms;
  } decoded_type;

endpackage

// file: code_keeper.sv
// Purpose: holds one setting code and refuses reserved codes
// Assumes: write strobe from the same clock
// Notes: a reserved code leaves the last legal code in force
`timescale 1ns/1ns
module code_keeper #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0,
  parameter logic [(2**W)-1:0] VALID = '1
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_wr, // write strobe
  input wire logic [W-1:0] i_code, // code written
  output logic [W-1:0] o_code // code in force
);

  logic [W-1:0] code_r;
  logic [W-1:0] code_nxt;

  // reserved codes are dropped silently
  always_comb begin
    code_nxt = code_r;
    if (i_wr && VALID[i_code]) begin
      code_nxt = i_code;
    end
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      code_r <= RST;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign o_code = code_r;

endmodule

// file: halt_cfg_bank.sv
// Purpose: loop settings words, field decode and motor halt sequencing
// Assumes: duty and back-EMF figures come from logic on the core clock
// Notes: the brake pin is asynchronous and is synchronised here
`timescale 1ns/1ns
module halt_cfg_bank
  import halt_cfg_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic i_core_clk, // core clock, 25 MHz
  input wire logic i_rst, // sync reset, high
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [31:0] i_reg_wdata, // write data
  output logic [31:0] o_reg_rdata, // read data, one cycle later
  input wire logic i_halt_req, // stop command, level
  input wire logic i_brake_pin, // brake pin, async
  input wire logic [9:0] i_duty_pm, // duty in permille
  input wire logic [14:0] i_emf_uv, // back-EMF magnitude in uV
  input wire logic i_pulse_raw, // raw speed pulse
  output logic o_speed_pulse, // gated speed pulse
  output drive_mode_type o_drive_mode, // bridge mode request
  output logic o_halt_done, // halt finished
  output decoded_type o_decoded // decoded settings
);

  // ****************************************
  // register storage
  // ****************************************
  logic [31:0] set_b_r;
  logic [31:0] set_b_nxt;
  logic [31:0] set_c_r;
  logic [31:0] set_c_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_b;
  logic [2:0] emf_code;
  logic [2:0] halt_code;
  logic [3:0] limit_code;
  logic [31:0] view_b;

  assign wr_b = i_reg_wr && (i_reg_addr == SETTINGS_B_ADDR);

  code_keeper #(.W(3), .RST(EMF_THR_RST), .VALID(EMF_THR_VALID)) u_emf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wr(wr_b),
    .i_code(i_reg_wdata[EMF_THR_LSB +: 3]),
    .o_code(emf_code)
  );

  code_keeper #(.W(3), .RST(HALT_RST), .VALID(HALT_VALID)) u_halt (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wr(wr_b),
    .i_code(i_reg_wdata[HALT_LSB +: 3]),
    .o_code(halt_code)
  );

  code_keeper #(.W(4), .RST(LIMIT_RST), .VALID(LIMIT_VALID)) u_limit (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wr(wr_b),
    .i_code(i_reg_wdata[LIMIT_LSB +: 4]),
    .o_code(limit_code)
  );

  // readback shows the codes in force
  always_comb begin
    view_b = set_b_r;
    view_b[EMF_THR_LSB +: 3] = emf_code;
    view_b[HALT_LSB +: 3] = halt_code;
    view_b[LIMIT_LSB +: 4] = limit_code;
  end

  always_comb begin
    set_b_nxt = set_b_r;
    set_c_nxt = set_c_r;
    rdata_nxt = rdata_r;
    if (wr_b) begin
      set_b_nxt = i_reg_wdata;
    end
    if (i_reg_wr && (i_reg_addr == SETTINGS_C_ADDR)) begin
      set_c_nxt = i_reg_wdata;
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        SETTINGS_B_ADDR: rdata_nxt = view_b;
        SETTINGS_C_ADDR: rdata_nxt = set_c_r;
        default: rdata_nxt = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // register bank flops
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      set_b_r <= SETTINGS_B_RST;
      set_c_r <= SETTINGS_C_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      set_b_r <= set_b_nxt;
      set_c_r <= set_c_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

  // ****************************************
  // field decode
  // ****************************************
  function automatic logic [9:0] duty_pm(input logic [2:0] code);
    case (code)
      3'h1: duty_pm = 10'h1F4; // 50 %
      3'h2: duty_pm = 10'h0FA; // 25 %
      3'h3: duty_pm = 10'h096; // 15 %
      3'h4: duty_pm = 10'h064; // 10 %
      3'h5: duty_pm = 10'h04B; // 7.5 %
      3'h6: duty_pm = 10'h032; // 5 %
      3'h7: duty_pm = 10'h019; // 2.5 %
      default: duty_pm = 10'h000; // immediate
    endcase
  endfunction

  decoded_type dec;

  always_comb begin
    case (emf_code)
      3'h0: dec.emf_thr_uv = 15'h03E8;
      3'h1: dec.emf_thr_uv = 15'h07D0;
      3'h2: dec.emf_thr_uv = 15'h1388;
      3'h3: dec.emf_thr_uv = 15'h2710;
      3'h4: dec.emf_thr_uv = 15'h4E20;
      default: dec.emf_thr_uv = 15'h7530;
    endcase
    // limit in millivolts, 100 mV per step
    dec.limit_mv = 11'(limit_code) * 11'h064;
    dec.spin_thr_pm = duty_pm(set_b_r[SPIN_THR_LSB +: 3]);
    dec.pin_thr_pm = duty_pm(set_b_r[PIN_THR_LSB +: 3]);
    case (set_b_r[BRAKE_TIME_LSB +: 4])
      4'h0: dec.brake_ms = 14'h0001;
      4'h1: dec.brake_ms = 14'h0002;
      4'h2: dec.brake_ms = 14'h0005;
      4'h3: dec.brake_ms = 14'h000A;
      4'h4: dec.brake_ms = 14'h000F;
      4'h5: dec.brake_ms = 14'h0019;
      4'h6: dec.brake_ms = 14'h0032;
      4'h7: dec.brake_ms = 14'h004B;
      4'h8: dec.brake_ms = 14'h0064;
      4'h9: dec.brake_ms = 14'h00FA;
      4'hA: dec.brake_ms = 14'h01F4;
      4'hB: dec.brake_ms = 14'h03E8;
      4'hC: dec.brake_ms = 14'h09C4;
      4'hD: dec.brake_ms = 14'h1388;
      4'hE: dec.brake_ms = 14'h2710;
      default: dec.brake_ms = 14'h3A98;
    endcase
  end

  assign o_decoded = dec;

  // ****************************************
  // brake pin synchroniser
  // ****************************************
  logic [2:0] pin_sync_r;
  logic [2:0] pin_sync_nxt;
  logic pin_lvl_r;
  logic pin_lvl_nxt;

  // level only moves when stages two and three agree
  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], i_brake_pin};
    pin_lvl_nxt = pin_lvl_r;
    if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_lvl_nxt = pin_sync_r[2];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_sync_r <= 3'h0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // ****************************************
  // halt sequencer
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT_DUTY,
    ST_BRAKING,
    ST_HALTED,
    ST_PIN_WAIT,
    ST_PIN_BRAKE
  } halt_state_type;

  halt_state_type state_r;
  halt_state_type state_nxt;
  drive_mode_type halt_mode;
  logic [$clog2(MS_DIV)-1:0] div_r;
  logic [$clog2(MS_DIV)-1:0] div_nxt;
  logic [13:0] ms_r;
  logic [13:0] ms_nxt;
  logic ms_tick;
  logic duty_gated;

  assign ms_tick = (div_r == ($clog2(MS_DIV))'(MS_DIV - 1));

  always_comb begin
    case (halt_code)
      3'h1: halt_mode = DRV_RECIRC;
      3'h2: halt_mode = DRV_LOW_BRAKE;
      3'h3: halt_mode = DRV_HIGH_BRAKE;
      3'h4: halt_mode = DRV_SPIN_DOWN;
      default: halt_mode = DRV_HIZ;
    endcase
  end

  // only braking and spin down wait for duty
  assign duty_gated = (halt_code == 3'h2) || (halt_code == 3'h3) || (halt_code == 3'h4);

  // next state; the stop command outranks the pin
  always_comb begin
    state_nxt = state_r;
    div_nxt = ms_tick ? '0 : div_r + 1'b1;
    ms_nxt = ms_r;
    case (state_r)
      ST_RUN: begin
        div_nxt = '0;
        ms_nxt = 14'h0000;
        if (i_halt_req) begin
          state_nxt = duty_gated ? ST_WAIT_DUTY : ST_BRAKING;
        end else if (pin_lvl_r) begin
          state_nxt = ST_PIN_WAIT;
        end
      end
      ST_WAIT_DUTY: begin
        div_nxt = '0;
        // immediate code or duty below threshold
        if (!i_halt_req) begin
          state_nxt = ST_RUN;
        end else if (dec.spin_thr_pm == 10'h000 || i_duty_pm < dec.spin_thr_pm) begin
          state_nxt = ST_BRAKING;
        end
      end
      ST_BRAKING: begin
        // hold the halt mode for the brake time
        if (ms_tick) begin
          ms_nxt = ms_r + 14'h0001;
          if (ms_r + 14'h0001 >= dec.brake_ms) begin
            state_nxt = ST_HALTED;
          end
        end
      end
      ST_HALTED: begin
        div_nxt = '0;
        if (!i_halt_req) begin
          state_nxt = ST_RUN;
        end
      end
      ST_PIN_WAIT: begin
        div_nxt = '0;
        // pin braking waits for its own duty threshold
        if (i_halt_req || !pin_lvl_r) begin
          state_nxt = ST_RUN;
        end else if (dec.pin_thr_pm == 10'h000 || i_duty_pm < dec.pin_thr_pm) begin
          state_nxt = ST_PIN_BRAKE;
        end
      end
      ST_PIN_BRAKE: begin
        div_nxt = '0;
        if (i_halt_req || !pin_lvl_r) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= ST_RUN;
      div_r <= '0;
      ms_r <= 14'h0000;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      ms_r <= ms_nxt;
    end
  end

  // bridge mode follows the state
  always_comb begin
    case (state_r)
      ST_BRAKING: o_drive_mode = halt_mode;
      ST_HALTED: o_drive_mode = DRV_HIZ; // coast once the halt time is over
      ST_PIN_BRAKE: o_drive_mode = DRV_LOW_BRAKE;
      default: o_drive_mode = DRV_RUN;
    endcase
  end

  assign o_halt_done = (state_r == ST_HALTED);

  // ****************************************
  // speed pulse gate
  // ****************************************
  logic pulse_r;
  logic pulse_nxt;
  logic driven;

  assign driven = (state_r == ST_RUN) || (state_r == ST_WAIT_DUTY) || (state_r == ST_PIN_WAIT);

  // clear config gates on back-EMF, set config on drive
  always_comb begin
    if (set_b_r[PULSE_CFG_BIT]) begin
      pulse_nxt = i_pulse_raw && driven;
    end else begin
      pulse_nxt = i_pulse_raw && (i_emf_uv >= dec.emf_thr_uv);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  assign o_speed_pulse = pulse_r;

endmodule

// file: halt_cfg_checker.sv
// Purpose: port assertions for the halt configuration bank
// Assumes: one core clock, sync reset high
// Notes: decode checks look only at the decoded struct
`timescale 1ns/1ns
module halt_cfg_checker
  import halt_cfg_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst, // sync reset
  input wire logic [7:0] i_reg_addr, // address
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [31:0] i_reg_wdata, // write data
  input wire logic [31:0] o_reg_rdata, // read data
  input wire logic i_halt_req, // stop command
  input wire logic i_brake_pin, // brake pin
  input wire logic [9:0] i_duty_pm, // duty
  input wire logic [14:0] i_emf_uv, // back-emf
  input wire logic i_pulse_raw, // raw pulse
  input wire logic o_speed_pulse, // gated pulse
  input drive_mode_type o_drive_mode, // bridge mode
  input wire logic o_halt_done, // halt done
  input decoded_type o_decoded // decoded settings
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_hole_read_zero: assert property (i_reg_rd && i_reg_addr != 8'h88 && i_reg_addr != 8'h8A
    |=> o_reg_rdata == 32'h0) else $error("unmapped read not zero");
  // reset clears read data and mode, checked through reset itself
  a_reset_clears: assert property (disable iff (1'b0) i_rst |=> o_reg_rdata == 32'h0
    && o_drive_mode == DRV_RUN && !o_halt_done) else $error("reset state wrong");
  a_done_is_hiz: assert property (o_halt_done |-> o_drive_mode == DRV_HIZ) else $error("done not hiz");
  a_done_release: assert property (o_halt_done && !i_halt_req |=> o_drive_mode == DRV_RUN
    && !o_halt_done) else $error("no resume");
  // pulse never appears without a raw pulse
  a_pulse_gated: assert property (o_speed_pulse |-> $past(i_pulse_raw)) else $error("pulse ungated");
  a_emf_table: assert property (o_decoded.emf_thr_uv inside {1000, 2000, 5000, 10000, 20000, 30000})
    else $error("emf threshold off table");
  // brake time stays in the table
  a_brake_table: assert property (o_decoded.brake_ms inside {1, 2, 5, 10, 15, 25, 50, 75, 100, 250,
    500, 1000, 2500, 5000, 10000, 15000}) else $error("brake time off table");
  // duty thresholds in the shared table
  a_duty_table: assert property (o_decoded.spin_thr_pm <= 10'h1F4 && o_decoded.pin_thr_pm <= 10'h1F4
    && o_decoded.spin_thr_pm inside {0, 500, 250, 150, 100, 75, 50, 25}
    && o_decoded.pin_thr_pm inside {0, 500, 250, 150, 100, 75, 50, 25}) else $error("duty threshold off table");
  a_limit_steps: assert property (o_decoded.limit_mv % 100 == 0 && o_decoded.limit_mv <= 1500)
    else $error("limit off steps");
  c_halt_done: cover property ($rose(o_halt_done));
  c_low_brake: cover property (o_drive_mode == DRV_LOW_BRAKE);
  c_pulse: cover property (o_speed_pulse);
endmodule
bind halt_cfg_bank halt_cfg_checker #(.MS_DIV(MS_DIV)) halt_cfg_checker_inst (.i_core_clk, .i_rst,
  .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_halt_req, .i_brake_pin,
  .i_duty_pm, .i_emf_uv, .i_pulse_raw, .o_speed_pulse, .o_drive_mode, .o_halt_done, .o_decoded);

// file: tb_halt_cfg_bank.sv
// Purpose: directed bench for the halt configuration bank
// Assumes: brake millisecond shortened to 4 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module tb_halt_cfg_bank;
  import halt_cfg_pkg::*;
  logic i_core_clk = 0;
  logic i_rst = 1;
  logic i_reg_wr = 0;
  logic i_reg_rd = 0;
  logic i_halt_req = 0;
  logic i_brake_pin = 0;
  logic i_pulse_raw = 0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  logic [31:0] o_reg_rdata;
  logic [31:0] q;
  logic [9:0] i_duty_pm = 10'h000;
  logic [14:0] i_emf_uv = 15'h0000;
  logic o_speed_pulse;
  logic o_halt_done;
  drive_mode_type o_drive_mode;
  decoded_type o_decoded;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int waited = 0;
  int emf_t[8] = '{1000, 2000, 5000, 10000, 20000, 30000, 0, 0};
  int brk_t[16] = '{1, 2, 5, 10, 15, 25, 50, 75, 100, 250, 500, 1000, 2500, 5000, 10000, 15000};
  int thr_t[8] = '{0, 500, 250, 150, 100, 75, 50, 25};

  halt_cfg_bank #(.MS_DIV(4)) halt_cfg_bank_inst (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wr,
    .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_halt_req, .i_brake_pin, .i_duty_pm, .i_emf_uv,
    .i_pulse_raw, .o_speed_pulse, .o_drive_mode, .o_halt_done, .o_decoded);

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  always #20 i_core_clk = ~i_core_clk;
  // a hang is cut short well past the few hundred cycles needed
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick(1);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    tick(1);
    i_reg_wr = 0;
  endtask
  // read data lands at the edge that takes the strobe
  task automatic rd(input logic [7:0] a);
    tick(1);
    i_reg_addr = a;
    i_reg_rd = 1;
    tick(1);
    i_reg_rd = 0;
    q = o_reg_rdata;
  endtask
  task automatic wait_for(input drive_mode_type m, input logic d);
    int n;
    n = 0;
    while ((o_drive_mode !== m || (d && o_halt_done !== 1'b1)) && n < 40) begin
      tick(1);
      n++;
    end
    waited = n;
  endtask
  function automatic logic [31:0] mk(input logic [2:0] e, input logic [2:0] h, input logic [3:0] b,
    input logic [2:0] s, input logic [2:0] p, input logic [3:0] l, input logic pc);
    return {7'h00, pc, e, h, b, s, p, 1'b0, l, 3'h0};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(SETTINGS_B_ADDR);
    chk(q, 32'h0, "word b reset");
    rd(8'h8A);
    chk(q, 32'h0140_0000, "word c reset");
    rd(8'h10);
    chk(q, 32'h0, "hole read");
    chk(32'(o_decoded.emf_thr_uv), 1000, "emf reset");
    chk(32'(o_decoded.brake_ms), 1, "brake reset");
    wr(8'h8A, 32'h1234_5678);
    rd(8'h8A);
    chk(q, 32'h1234_5678, "word c rw");
    $display("test reset done");
  endtask
  // every code of each field but the halt code and the pulse config bit, reserved ones keep the last legal code
  task automatic t_fields();
    logic [2:0] ce;
    logic [3:0] cl;
    ce = 3'h0;
    cl = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (i % 8 < 6) ce = 3'(i);
      if (4'(i + 8) != 4'h0) cl = 4'(i + 8);
      wr(SETTINGS_B_ADDR, mk(3'(i), 3'h0, 4'(i), 3'(i), 3'(7 - i), 4'(i + 8), 1'b0));
      rd(SETTINGS_B_ADDR);
      chk(q, mk(ce, 3'h0, 4'(i), 3'(i), 3'(7 - i), cl, 1'b0), "word b");
      chk(32'(o_decoded.emf_thr_uv), emf_t[ce], "emf");
      chk(32'(o_decoded.brake_ms), brk_t[i], "brake");
      chk(32'(o_decoded.spin_thr_pm), thr_t[i % 8], "spin thr");
      chk(32'(o_decoded.pin_thr_pm), thr_t[(7 - i) & 7], "pin thr");
      chk(32'(o_decoded.limit_mv), cl * 100, "limit");
    end
    $display("test fields done");
  endtask
  task automatic t_halt();
    int em;
    for (int m = 0; m < 6; m++) begin
      em = (m == 5) ? 4 : m;
      wr(SETTINGS_B_ADDR, mk(3'h0, 3'(m), 4'h0, 3'h1, 3'h0, 4'h1, 1'b0));
      rd(SETTINGS_B_ADDR);
      chk(32'(q[20:18]), em, "halt code");
      i_duty_pm = 10'h258;
      i_halt_req = 1;
      if (em >= 2) begin
        tick(6);
        chk(o_drive_mode, DRV_RUN, "early brake");
        i_duty_pm = 10'h064;
      end
      wait_for(drive_mode_type'(em + 1), 1'b0);
      chk(o_drive_mode, em + 1, "halt mode");
      wait_for(DRV_HIZ, 1'b1);
      chk(o_halt_done, 1'b1, "halt done");
      // one ms is four bench cycles, so code 0 brakes for four
      chk(waited, brk_t[0] * 4, "brake cycles");
      i_halt_req = 0;
      tick(1);
      chk(o_drive_mode, DRV_RUN, "resume");
    end
    $display("test halt done");
  endtask
  task automatic t_pin();
    wr(SETTINGS_B_ADDR, mk(3'h0, 3'h0, 4'h0, 3'h0, 3'h2, 4'h1, 1'b0));
    i_duty_pm = 10'h258;
    i_brake_pin = 1;
    tick(8);
    chk(o_drive_mode, DRV_RUN, "pin early");
    i_duty_pm = 10'h064;
    wait_for(DRV_LOW_BRAKE, 1'b0);
    chk(o_drive_mode, DRV_LOW_BRAKE, "pin brake");
    i_brake_pin = 0;
    wait_for(DRV_RUN, 1'b0);
    chk(o_drive_mode, DRV_RUN, "pin release");
    $display("test pin done");
  endtask
  task automatic t_pulse();
    wr(SETTINGS_B_ADDR, mk(3'h0, 3'h0, 4'h0, 3'h0, 3'h0, 4'h1, 1'b0));
    i_pulse_raw = 1;
    i_emf_uv = 15'h07D0;
    tick(3);
    chk(o_speed_pulse, 1'b1, "pulse above");
    i_emf_uv = 15'h01F4;
    tick(3);
    chk(o_speed_pulse, 1'b0, "pulse below");
    wr(SETTINGS_B_ADDR, mk(3'h0, 3'h0, 4'h0, 3'h0, 3'h0, 4'h1, 1'b1));
    tick(2);
    chk(o_speed_pulse, 1'b1, "pulse driven");
    $display("test pulse done");
  endtask

  initial begin
    tick(2);
    i_rst = 0;
    t_reset();
    t_fields();
    t_halt();
    t_pin();
    t_pulse();
    wrap_up();
  end
endmodule
